// ### hw/video_serializer_input.sv
// Parallel input front end of a video serializer: mode, mapping, timing.
// Assumes pins synchronous to clk and an APB master for the registers.
//
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "vser_consts.svh"
// Contract
// RQ1: Every parallel input word is registered on the rising clock edge.
// RQ2: Bus width pin high selects 20 bits, low selects 10 bits.
// RQ3: Path select high and ASI select low give SMPTE mode.
// RQ4: Path select low, ASI and rate select high give ASI mode.
// RQ5: Path select and ASI select both low give data-through mode.
// RQ6: In 20-bit SMPTE the source puts luma high and chroma low.
// RQ7: In 10-bit operation only the upper ten lines are used.
// RQ8: In ASI mode the controller holds the bus width pin low.
// RQ9: In ASI mode the byte comes from lines 17 down to 10.
// RQ10: In ASI mode line 19 requests sync fill, line 18 flags specials.
// RQ11: In ASI mode the source holds the lower ten lines high.
// RQ12: Sync fill inserts K28.5 commas, encoded after insertion.
// RQ13: The source flags special characters high and plain data low.
// RQ14: ASI bytes are 8b/10b encoded with stuffing before serialization.
// RQ15: Data-through forwards words unchanged at the selected width.
// RQ16: SMPTE data is scrambled then NRZ-to-NRZI encoded.
// RQ17: The source clocks the bus at the rate its format sets.
// RQ18: Processing pin gates all features; register bits disable each one.
// RQ19: SMPTE mode measures total and active line and frame lengths.
// RQ20: Embedded select low takes timing from the H, V, F pins.
// RQ21: Embedded select high takes timing from 8- or 10-bit TRS words.
// RQ22: 8-bit TRS words are remapped only while processing is enabled.
// RQ23: Lock needs one full frame; timing drops at once when lost.
// RQ24: Control bit low means active-line H, high means TRS-based H.
// RQ25: Active-line H stays high through all horizontal blanking.
// RQ26: Undefined mode pin combinations behave as data-through mode.
module video_serializer_input (
	input  wire logic         clk,
	input  wire logic         nrst,
	input  wire logic [7:0]   paddr,
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [31:0]  pwdata,
	output var  logic [31:0]  prdata,
	output wire logic         pready,
	output wire logic         pslverr,
	input  wire logic         processing_path_select,
	input  wire logic         asi_mode_select,
	input  wire logic         rate_select,
	input  wire logic         bus_width_select,
	input  wire logic         embedded_timing_select,
	input  wire logic         processing_enable,
	input  wire logic [19:0]  din,
	input  wire logic         h_in,
	input  wire logic         v_in,
	input  wire logic         field_timing_in,
	output var  logic [19:0]  ser_data,
	output var  logic         ser_width20,
	output var  vser_pkg::mode_t ser_mode,
	output var  logic         timing_locked
);
	import vser_pkg::*;

	logic [19:0] din_reg;
	logic        pps_reg;
	logic        asi_reg;
	logic        rate_reg;
	logic        bw_reg;
	logic        ets_reg;
	logic        pen_reg;
	logic        h_reg;
	logic        v_reg;
	logic        f_reg;
	logic [2:0]  ctrl_reg;
	logic [31:0] prdata_next;
	logic [19:0] vid;
	logic [8:0]  scr_reg;
	logic [8:0]  scr_next;
	logic        nrzi_reg;
	logic        nrzi_next;
	logic        bit_s;
	logic [19:0] smpte_word;
	logic [19:0] ser_next;
	logic [2:0]  ff_hist;
	logic [2:0]  zz_hist;
	logic        trs_h;
	logic        trs_v;
	logic        trs_f;
	logic        h_d;
	logic        v_d;
	logic [11:0] wd_cnt;
	count_t      pix_cnt;
	count_t      act_cnt;
	count_t      line_cnt;
	count_t      aline_cnt;
	count_t      tot_len;
	count_t      act_len;
	count_t      tot_lines;
	count_t      act_lines;
	logic        frame_seen;
	mode_t       mode;
	enc_if       e ();

	// Input capture stage
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			din_reg  <= 20'h00000;
			pps_reg  <= 1'b0;
			asi_reg  <= 1'b0;
			rate_reg <= 1'b0;
			bw_reg   <= 1'b0;
			ets_reg  <= 1'b0;
			pen_reg  <= 1'b0;
			h_reg    <= 1'b0;
			v_reg    <= 1'b0;
			f_reg    <= 1'b0;
		end else begin
			din_reg  <= din; // RQ1
			pps_reg  <= processing_path_select;
			asi_reg  <= asi_mode_select;
			rate_reg <= rate_select;
			bw_reg   <= bus_width_select;
			ets_reg  <= embedded_timing_select;
			pen_reg  <= processing_enable;
			h_reg    <= h_in;
			v_reg    <= v_in;
			f_reg    <= field_timing_in;
		end
	end

	wire is_smpte = pps_reg & ~asi_reg; // RQ3
	wire is_asi   = ~pps_reg & asi_reg & rate_reg; // RQ4
	wire is_thru  = ~pps_reg & ~asi_reg; // RQ5
	assign mode = is_smpte ? MODE_SMPTE :
		is_asi ? MODE_ASI : MODE_THRU; // RQ26
	wire wide = bw_reg & ~is_asi; // RQ2

	wire h_cfg     = ctrl_reg[`CTRL_HCFG];
	wire remap_on  = pen_reg & ~ctrl_reg[`CTRL_REMAP_DIS]; // RQ22
	wire detect_on = is_smpte & pen_reg & ~ctrl_reg[`CTRL_DETECT_DIS]; // RQ18

	// Reserved TRS ranges fold onto their 10-bit values
	for (genvar ch = 0; ch < 2; ch++) begin : g_remap
		wire [9:0] w    = din_reg[ch*10 +: 10];
		wire       ones = &w[9:2];
		wire       zero = ~|w[9:2];
		assign vid[ch*10 +: 10] = !remap_on ? w : ones ? 10'h3ff :
			zero ? 10'h000 : w; // RQ22
	end

	// Chroma bits go out first; narrow words use the upper lines only
	always_comb begin
		scr_next   = scr_reg;
		nrzi_next  = nrzi_reg;
		smpte_word = 20'h00000;
		bit_s      = 1'b0;
		for (int i = 0; i < 20; i++) begin
			if (wide || i >= 10) begin
				bit_s = vid[i] ^ scr_next[`SCR_TAP_A] ^
					scr_next[`SCR_TAP_B]; // RQ16
				scr_next = {scr_next[7:0], bit_s};
				nrzi_next = nrzi_next ^ bit_s; // RQ16
				smpte_word[i] = nrzi_next;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			scr_reg  <= 9'h000;
			nrzi_reg <= 1'b0;
		end else if (is_smpte) begin
			scr_reg  <= scr_next;
			nrzi_reg <= nrzi_next;
		end
	end

	// ASI byte, control bits and sync fill
	wire sync_fill = din_reg[19]; // RQ10
	assign e.en       = is_asi;
	assign e.byte_val = sync_fill ? `K28_5 : din_reg[17:10]; // RQ12
	assign e.k        = sync_fill | din_reg[18]; // RQ10

	asi_encoder u_enc (
		.clk  (clk),
		.nrst (nrst),
		.e    (e.enc)
	); // RQ14

	always_comb begin
		case (mode)
			MODE_SMPTE: ser_next = smpte_word;
			MODE_ASI:   ser_next = {e.code, 10'h000}; // RQ9
			default:    ser_next = wide ? din_reg :
				{din_reg[19:10], 10'h000}; // RQ15
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ser_data    <= 20'h00000;
			ser_width20 <= 1'b0;
			ser_mode    <= MODE_THRU;
		end else begin
			ser_data    <= ser_next; // RQ7
			ser_width20 <= wide;
			ser_mode    <= mode;
		end
	end

	// TRS preamble in either word size; XYZ carries F, V, H
	wire [9:0] luma    = din_reg[19:10];
	wire       trs_hit = ff_hist[2] & zz_hist[1] & zz_hist[0]; // RQ21

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ff_hist <= 3'h0;
			zz_hist <= 3'h0;
			trs_h   <= 1'b0;
			trs_v   <= 1'b0;
			trs_f   <= 1'b0;
		end else begin
			ff_hist <= {ff_hist[1:0], &luma[9:2]};
			zz_hist <= {zz_hist[1:0], ~|luma[9:2]};
			if (trs_hit) begin
				trs_h <= luma[6];
				trs_v <= luma[7];
				trs_f <= luma[8];
			end
		end
	end

	wire h_s = ets_reg ? trs_h : h_reg; // RQ20
	wire v_s = ets_reg ? trs_v : v_reg;
	wire f_s = ets_reg ? trs_f : f_reg;
	wire line_start  = h_s & ~h_d;
	wire frame_start = v_s & ~v_d & ~f_s;
	wire lost        = wd_cnt == `LOSS_CYC;
	wire run         = detect_on & ~lost;
	wire act_big     = act_cnt > `TRS_WORDS;
	wire [15:0] act_adj = h_cfg ? (act_big ? act_cnt - `TRS_WORDS :
		16'h0000) : act_cnt; // RQ24

	// Watchdog on H activity
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			h_d    <= 1'b0;
			v_d    <= 1'b0;
			wd_cnt <= 12'h000;
		end else begin
			h_d <= h_s;
			v_d <= v_s;
			if (!detect_on || h_s != h_d)
				wd_cnt <= 12'h000;
			else if (!lost)
				wd_cnt <= wd_cnt + 12'h001;
		end
	end

	// Sample counts per line
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pix_cnt <= 16'h0000;
			act_cnt <= 16'h0000;
			tot_len <= 16'h0000;
			act_len <= 16'h0000;
		end else if (!run) begin
			pix_cnt <= 16'h0000;
			act_cnt <= 16'h0000;
			tot_len <= 16'h0000; // RQ23
			act_len <= 16'h0000;
		end else if (line_start) begin
			tot_len <= pix_cnt; // RQ19
			act_len <= act_adj;
			pix_cnt <= 16'h0001;
			act_cnt <= 16'h0000;
		end else begin
			pix_cnt <= pix_cnt + 16'h0001;
			if (!h_s)
				act_cnt <= act_cnt + 16'h0001;
		end
	end

	// Line counts per frame and lock
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			line_cnt      <= 16'h0000;
			aline_cnt     <= 16'h0000;
			tot_lines     <= 16'h0000;
			act_lines     <= 16'h0000;
			frame_seen    <= 1'b0;
			timing_locked <= 1'b0;
		end else if (!run) begin
			line_cnt      <= 16'h0000;
			aline_cnt     <= 16'h0000;
			tot_lines     <= 16'h0000;
			act_lines     <= 16'h0000;
			frame_seen    <= 1'b0;
			timing_locked <= 1'b0; // RQ23
		end else if (frame_start) begin
			tot_lines     <= line_cnt; // RQ19
			act_lines     <= aline_cnt;
			// The line that opens the frame belongs to it
			line_cnt      <= {15'h0000, line_start}; // RQ19
			aline_cnt     <= 16'h0000;
			frame_seen    <= 1'b1;
			timing_locked <= frame_seen; // RQ23
		end else if (line_start) begin
			line_cnt <= line_cnt + 16'h0001;
			if (!v_s)
				aline_cnt <= aline_cnt + 16'h0001;
		end
	end

	// APB slave, zero wait states
	wire sel_ctrl  = paddr == `OFS_CTRL;
	wire sel_stat  = paddr == `OFS_STATUS;
	wire sel_line  = paddr == `OFS_LINE;
	wire sel_frame = paddr == `OFS_FRAME;
	wire hit       = sel_ctrl | sel_stat | sel_line | sel_frame;
	wire setup     = psel & ~penable;
	wire wr_ctrl   = psel & penable & pwrite & sel_ctrl;

	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~hit;

	always_comb begin
		if (sel_ctrl)
			prdata_next = {29'h00000000, ctrl_reg};
		else if (sel_stat)
			prdata_next = {28'h0000000, wide, timing_locked, mode};
		else if (sel_line)
			prdata_next = {act_len, tot_len};
		else if (sel_frame)
			prdata_next = {act_lines, tot_lines};
		else
			prdata_next = 32'h00000000;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_reg <= `CTRL_RESET; // RQ24
			prdata   <= 32'h00000000;
		end else begin
			if (wr_ctrl)
				ctrl_reg <= pwdata[2:0];
			if (setup)
				prdata <= prdata_next;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	property p_mode_smpte;
		processing_path_select && !asi_mode_select |=> ##1
			ser_mode == MODE_SMPTE;
	endproperty
	a_mode_smpte: assert property (p_mode_smpte) // RQ3
		else $error("SMPTE mode not entered");

	property p_mode_asi;
		!processing_path_select && asi_mode_select && rate_select
			|=> ##1 ser_mode == MODE_ASI;
	endproperty
	a_mode_asi: assert property (p_mode_asi) // RQ4
		else $error("ASI mode not entered");

	property p_mode_thru;
		!processing_path_select && !asi_mode_select |=> ##1
			ser_mode == MODE_THRU;
	endproperty
	a_mode_thru: assert property (p_mode_thru) // RQ5
		else $error("data-through mode not entered");

	property p_thru_wide;
		is_thru && bw_reg |=> ser_data == $past(din_reg);
	endproperty
	a_thru_wide: assert property (p_thru_wide) // RQ15
		else $error("through word altered");

	property p_narrow;
		!bw_reg && !is_smpte |=> ser_data[9:0] == 10'h000 && !ser_width20;
	endproperty
	a_narrow: assert property (p_narrow) // RQ7
		else $error("lower lines used in narrow mode");

	property p_sync_fill;
		is_asi && din_reg[19] |-> e.byte_val == `K28_5 && e.k;
	endproperty
	a_sync_fill: assert property (p_sync_fill) // RQ12
		else $error("sync fill not inserted");

	property p_asi_code;
		is_asi |=> ser_data[19:10] == $past(e.code) && !ser_width20;
	endproperty
	a_asi_code: assert property (p_asi_code) // RQ14
		else $error("ASI code not forwarded");

	property p_loss;
		lost |=> !timing_locked && tot_len == 16'h0000;
	endproperty
	a_loss: assert property (p_loss) // RQ23
		else $error("timing kept after loss");

	property p_remap_gate;
		!pen_reg && !is_asi && is_smpte |-> vid == din_reg;
	endproperty
	a_remap_gate: assert property (p_remap_gate) // RQ22
		else $error("remap active without processing");

	c_asi_fill: cover property (is_asi && sync_fill);
	c_locked:   cover property ($rose(timing_locked));
	c_trs:      cover property (ets_reg && trs_hit);
	c_wide:     cover property (is_thru && wide);
endmodule : video_serializer_input
`default_nettype wire

// ### hw/vser_consts.svh
// Offsets, field positions, reset values and counts of the video input front end.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef VSER_CONSTS_SVH
`define VSER_CONSTS_SVH
`define OFS_CTRL        8'h00
`define OFS_STATUS      8'h04
`define OFS_LINE        8'h08
`define OFS_FRAME       8'h0c
`define CTRL_HCFG       0
`define CTRL_REMAP_DIS  1
`define CTRL_DETECT_DIS 2
`define CTRL_RESET      3'h0
`define LOSS_CYC        12'hfff
`define TRS_WORDS       16'h0004
`define K28_5           8'hbc
`define K28_X           5'h1c
`define K28_6B          6'h0f
`define SCR_TAP_A       3
`define SCR_TAP_B       8
`endif

// ### hw/vser_pkg.sv
// Types shared by the video input front end and its ASI encoder.
// Assumes nothing of its surroundings.
package vser_pkg;
	typedef enum logic [1:0] {MODE_SMPTE, MODE_ASI, MODE_THRU} mode_t;
	typedef logic [15:0] count_t;
endpackage : vser_pkg

// ### hw/enc_if.sv
// Byte and code path between the front end and its 8b/10b encoder.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface enc_if;
	logic       en;
	logic [7:0] byte_val;
	logic       k;
	logic [9:0] code;
	modport src (output en, output byte_val, output k, input code);
	modport enc (input en, input byte_val, input k, output code);
endinterface : enc_if
`default_nettype wire

// ### hw/asi_encoder.sv
// 8b/10b encoder with running disparity for the ASI path.
// Assumes the source holds en high only while ASI mode is active.
`timescale 1ns/1ps
`default_nettype none
module asi_encoder (
	input wire logic clk,
	input wire logic nrst,
	enc_if.enc       e
);
	import vser_pkg::*;

	logic       rd_reg;
	logic       rd_next;
	logic [5:0] c6;
	logic [3:0] c4;
	logic       rd1;
	logic       alt;
	logic [4:0] x;
	logic [2:0] y;

	function automatic logic [5:0] tbl6(input logic [4:0] v);
		logic [5:0] r;
		r = 6'h00;
		case (v)
			5'h00: r = 6'b100111; 5'h01: r = 6'b011101;
			5'h02: r = 6'b101101; 5'h03: r = 6'b110001;
			5'h04: r = 6'b110101; 5'h05: r = 6'b101001;
			5'h06: r = 6'b011001; 5'h07: r = 6'b111000;
			5'h08: r = 6'b111001; 5'h09: r = 6'b100101;
			5'h0a: r = 6'b010101; 5'h0b: r = 6'b110100;
			5'h0c: r = 6'b001101; 5'h0d: r = 6'b101100;
			5'h0e: r = 6'b011100; 5'h0f: r = 6'b010111;
			5'h10: r = 6'b011011; 5'h11: r = 6'b100011;
			5'h12: r = 6'b010011; 5'h13: r = 6'b110010;
			5'h14: r = 6'b001011; 5'h15: r = 6'b101010;
			5'h16: r = 6'b011010; 5'h17: r = 6'b111010;
			5'h18: r = 6'b110011; 5'h19: r = 6'b100110;
			5'h1a: r = 6'b010110; 5'h1b: r = 6'b110110;
			5'h1c: r = 6'b001110; 5'h1d: r = 6'b101110;
			5'h1e: r = 6'b011110; default: r = 6'b101011;
		endcase
		return r;
	endfunction : tbl6

	function automatic logic [3:0] tbl4(input logic [2:0] v, input logic kc);
		logic [3:0] r;
		r = 4'h0;
		case (v)
			3'h0: r = 4'b1011;
			3'h1: r = kc ? 4'b0110 : 4'b1001;
			3'h2: r = kc ? 4'b1010 : 4'b0101;
			3'h3: r = 4'b1100;
			3'h4: r = 4'b1101;
			3'h5: r = kc ? 4'b0101 : 4'b1010;
			3'h6: r = kc ? 4'b1001 : 4'b0110;
			default: r = kc ? 4'b0111 : 4'b1110;
		endcase
		return r;
	endfunction : tbl4

	assign x = e.byte_val[4:0];
	assign y = e.byte_val[7:5];

	// Codes are held for negative disparity; for positive, unbalanced codes and those for x 7, y 3 or K are inverted
	always_comb begin
		c6 = (e.k && x == `K28_X) ? `K28_6B : tbl6(x);
		if (rd_reg && ($countones(c6) != 3 || x == 5'h07))
			c6 = ~c6;
		rd1 = rd_reg ^ ($countones(c6) != 3);
		alt = (y == 3'h7) && ((!rd1 && (x == 5'h11 || x == 5'h12 ||
			x == 5'h14)) || (rd1 && (x == 5'h0b || x == 5'h0d ||
			x == 5'h0e)));
		c4 = (alt && !e.k) ? 4'b0111 : tbl4(y, e.k);
		if (rd1 && (e.k || $countones(c4) != 2 || y == 3'h3))
			c4 = ~c4;
		rd_next = rd1 ^ ($countones(c4) != 2);
	end

	assign e.code = {c6, c4};

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			rd_reg <= 1'b0;
		else if (e.en)
			rd_reg <= rd_next;
	end
endmodule : asi_encoder
`default_nettype wire

// ### tb/video_source.sv
// Upstream source model: video words, transport bytes and H, V, F timing.
// Assumes the bench picks the format and the word that is presented.
`timescale 1ns/1ps
`default_nettype none
module video_source #(
	parameter int LINE_LEN = 20,
	parameter int H_BLANK  = 4,
	parameter int N_LINES  = 6,
	parameter int V_BLANK  = 2
) (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic [19:0] word,
	input  wire logic        asi,
	input  wire logic        wide,
	input  wire logic        sync_req,
	input  wire logic        special,
	input  wire logic        timing_run,
	input  wire logic        trs,
	output var  logic [19:0] din,
	output var  logic        h_in,
	output var  logic        v_in,
	output var  logic        field_timing_in
);
	logic [9:0] float_reg;
	int         pix_reg;
	int         line_reg;
	logic [9:0] trs_word;
	logic [9:0] luma;
	logic       v_bit;
	logic       h_bit;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			float_reg <= 10'h155;
			pix_reg   <= 0;
			line_reg  <= 0;
		end else begin
			float_reg <= ~float_reg;
			if (timing_run) begin
				pix_reg <= (pix_reg == LINE_LEN - 1) ? 0 : pix_reg + 1;
				if (pix_reg == LINE_LEN - 1)
					line_reg <= (line_reg == N_LINES - 1) ? 0 : line_reg + 1;
			end
		end
	end

	// Timing words: EAV in pixels 0-3 in 8-bit form, SAV in 4-7 in 10-bit
	assign v_bit = line_reg < V_BLANK;
	assign h_bit = pix_reg < H_BLANK;
	always_comb begin
		case (pix_reg)
			0:          trs_word = 10'h3fc;
			4:          trs_word = 10'h3ff;
			1, 2, 5, 6: trs_word = 10'h000;
			default:    trs_word = {2'b10, v_bit, h_bit, v_bit ^ h_bit, h_bit,
				v_bit, v_bit ^ h_bit, 2'b00};
		endcase
	end
	assign luma = (trs && timing_run && pix_reg < 8) ? trs_word : word[19:10];

	// Undriven lower lines in narrow operation toggle rather than hold
	assign din = asi ? {sync_req, special, word[17:10], 10'h3ff}
		: wide ? {luma, word[9:0]} : {luma, float_reg};
	assign h_in = timing_run && (pix_reg < H_BLANK);
	assign v_in = timing_run && (line_reg < V_BLANK);
	assign field_timing_in = 1'b0;
endmodule : video_source
`default_nettype wire

// ### tb/video_serializer_input_tb.sv
// Self-checking bench for the video input front end.
// Assumes the design files and the source model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module video_serializer_input_tb;
	import vser_pkg::*;
	logic        clk;
	logic        nrst;
	logic [7:0]  paddr;
	logic        psel, penable, pwrite, pready, pslverr;
	logic [31:0] pwdata, prdata, rd;
	logic        path_sel, asi_sel, rate_sel, wide_sel, asi_on;
	logic [19:0] word, din, ser_data;
	logic        sync_req, special, timing_run, err;
	logic        ets_sel, pen_sel, trs;
	logic        h_in, v_in, f_in, ser_width20, timing_locked;
	mode_t       ser_mode;
	logic [9:0]  code_a, code_b;
	int          n_mismatch;
	int          comparisons;
	logic [3:0]  pins_tab [7] = '{4'hb, 4'h8, 4'h6, 4'h3, 4'h0, 4'h4, 4'he};
	mode_t       mode_tab [7] = '{MODE_SMPTE, MODE_SMPTE, MODE_ASI,
		MODE_THRU, MODE_THRU, MODE_THRU, MODE_THRU};

	assign asi_on = ~path_sel & asi_sel & rate_sel;

	video_serializer_input DUT (.clk(clk), .nrst(nrst), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.processing_path_select(path_sel), .asi_mode_select(asi_sel),
		.rate_select(rate_sel), .bus_width_select(wide_sel),
		.embedded_timing_select(ets_sel), .processing_enable(pen_sel),
		.din(din), .h_in(h_in), .v_in(v_in), .field_timing_in(f_in),
		.ser_data(ser_data), .ser_width20(ser_width20),
		.ser_mode(ser_mode), .timing_locked(timing_locked));

	video_source src (.clk(clk), .nrst(nrst), .word(word), .asi(asi_on),
		.wide(wide_sel), .sync_req(sync_req), .special(special),
		.timing_run(timing_run), .trs(trs), .din(din), .h_in(h_in),
		.v_in(v_in), .field_timing_in(f_in));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic conclude;
		if (n_mismatch == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : conclude

	task automatic check_val(input string name, input logic [31:0] exp,
		input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask : check_val

	task automatic check_mode(input mode_t exp, input mode_t got);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value ser_mode expected %h seen %h", exp, got);
		end
	endtask : check_mode

	task automatic apb_xfer(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb_xfer

	task automatic apb_write(input logic [7:0] a, input logic [31:0] d);
		apb_xfer(1'b1, a, d);
	endtask : apb_write

	task automatic apb_read(input logic [7:0] a);
		apb_xfer(1'b0, a, 32'h0);
	endtask : apb_read

	task automatic set_pins(input logic [3:0] p);
		@(posedge clk);
		{path_sel, asi_sel, rate_sel, wide_sel} <= p;
		repeat (4) @(posedge clk);
	endtask : set_pins

	// Two successive codes: the first must be one of c0 or c1
	task automatic asi_pair(input logic [9:0] s, input logic [9:0] c0,
		input logic [9:0] c1, input logic alt);
		{sync_req, special, word[17:10]} <= s;
		repeat (4) @(posedge clk);
		code_a = ser_data[19:10];
		@(posedge clk);
		code_b = ser_data[19:10];
		check_val("code", 32'h1, {31'h0, code_a === c0 || code_a === c1});
		check_val("disparity", {31'h0, alt}, {31'h0, code_a !== code_b});
		check_val("asi_width", 32'h0, {31'h0, ser_width20});
	endtask : asi_pair

	initial begin
		#(20000 * 25);
		n_mismatch++;
		conclude();
	end

	initial begin
		logic w;
		{nrst, psel, penable, pwrite, paddr, pwdata} = '0;
		{path_sel, asi_sel, rate_sel, wide_sel} = 4'h0;
		{sync_req, special, timing_run} = 3'h0;
		{ets_sel, trs} = 2'h0;
		pen_sel = 1'b1;
		word = 20'ha5c3e;
		n_mismatch = 0;
		comparisons = 0;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		apb_read(8'h00);
		check_val("ctrl_reset", 32'h0, rd);
		apb_write(8'h00, 32'hffffffff);
		apb_read(8'h00);
		check_val("ctrl", 32'h7, rd);
		apb_write(8'h00, 32'h0);
		apb_read(8'h10);
		check_val("unmapped_err", 32'h1, {31'h0, err});
		check_val("unmapped_data", 32'h0, rd);
		for (int i = 0; i < 7; i++) begin
			set_pins(pins_tab[i]);
			w = pins_tab[i][0];
			check_mode(mode_tab[i], ser_mode);
			check_val("width", {31'h0, w}, {31'h0, ser_width20});
			if (mode_tab[i] == MODE_THRU)
				check_val("through", {12'h0, w ? word : {word[19:10], 10'h0}},
					{12'h0, ser_data});
			apb_read(8'h04);
			check_val("status", {28'h0, w, 1'b0, mode_tab[i]}, rd);
		end
		set_pins(4'h6);
		asi_pair(10'h255, 10'h0fa, 10'h305, 1'b1);
		asi_pair(10'h1bc, 10'h0fa, 10'h305, 1'b1);
		asi_pair(10'h080, 10'h272, 10'h18d, 1'b0);
		sync_req <= 1'b0;
		special  <= 1'b0;
		set_pins(4'hb);
		timing_run <= 1'b1;
		repeat (60) @(posedge clk);
		check_val("early_lock", 32'h0, {31'h0, timing_locked});
		repeat (200) @(posedge clk);
		check_val("lock", 32'h1, {31'h0, timing_locked});
		apb_read(8'h08);
		check_val("line", 32'h00100014, rd);
		apb_read(8'h0c);
		check_val("frame", 32'h00040006, rd);
		apb_write(8'h00, 32'h1);
		repeat (60) @(posedge clk);
		apb_read(8'h08);
		check_val("line_trs", 32'h000c0014, rd);
		apb_write(8'h00, 32'h0);
		timing_run <= 1'b0;
		repeat (4000) @(posedge clk);
		check_val("held_lock", 32'h1, {31'h0, timing_locked});
		repeat (200) @(posedge clk);
		check_val("lost_lock", 32'h0, {31'h0, timing_locked});
		apb_read(8'h08);
		check_val("line_lost", 32'h0, rd);
		ets_sel    <= 1'b1;
		trs        <= 1'b1;
		timing_run <= 1'b1;
		repeat (500) @(posedge clk);
		check_val("trs_lock", 32'h1, {31'h0, timing_locked});
		apb_read(8'h08);
		check_val("trs_line", 32'h00100014, rd);
		apb_read(8'h0c);
		check_val("trs_frame", 32'h00040006, rd);
		pen_sel <= 1'b0;
		repeat (4) @(posedge clk);
		check_val("pen_off_lock", 32'h0, {31'h0, timing_locked});
		conclude();
	end
endmodule : video_serializer_input_tb
`default_nettype wire
